//--- hdl/cmc_pkg.sv
// constants, types and register map for the comparator control logic
// assumes a 32-bit ahb-lite slave and one 100 MHz clock domain
package cmc_pkg;
	localparam logic [7:0] CMC_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] CMC_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] CMC_OFS_OUT = 8'h08;
	localparam logic [7:0] CMC_OFS_IRQ = 8'h0C;
	localparam logic [7:0] CMC_OFS_PORT = 8'h10;
	localparam int CMC_EN_BIT = 7;
	localparam int CMC_OUT_BIT = 6;
	localparam int CMC_POL_BIT = 4;
	localparam int CMC_SP_BIT = 2;
	localparam int CMC_HYS_BIT = 1;
	localparam int CMC_SYNC_BIT = 0;
	localparam int CMC_RISE_BIT = 7;
	localparam int CMC_FALL_BIT = 6;
	localparam int CMC_IRQ_FLAG_BIT = 0;
	localparam int CMC_IRQ_IE_BIT = 1;
	localparam int CMC_IRQ_SD_BIT = 2;
	localparam logic [7:0] CMC_CTRL0_RST = 8'h04;
	localparam logic [7:0] CMC_CTRL0_WMASK = 8'h97;
	localparam logic [7:0] CMC_CTRL1_RST = 8'h00;
	localparam int CMC_PORT_W = 8;
	// timer1 clock source encoding
	localparam logic [1:0] CMC_T1_FOSC4 = 2'h0;
	localparam logic [1:0] CMC_T1_FOSC = 2'h1;
	localparam logic [1:0] CMC_T1_EXT = 2'h2;
	localparam logic [1:0] CMC_T1_LFINT = 2'h3;
	typedef enum logic [1:0] {
		CMC_ADDR = 2'b01,
		CMC_DATA = 2'b10
	} cmc_state_t;
endpackage

//--- hdl/cmc_out_if.sv
// conditioned-output bundle between the top and the edge unit
// assumes one clock domain
`timescale 1ns/1ps
interface cmc_out_if;
	logic level;
	logic rise_en;
	logic fall_en;
	logic clr;
	logic flag;
	modport src (output level, output rise_en, output fall_en, output clr, input flag);
	modport edge_unit (input level, input rise_en, input fall_en, input clr, output flag);
endinterface

//--- hdl/cmc_sync2.sv
// two-stage synchroniser for one asynchronous bit
// assumes the input may change at any time
`timescale 1ns/1ps
module cmc_sync2 (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic d_async,
	output logic q
);
	import cmc_pkg::*;
	logic meta_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_reg <= d_async;
			q <= meta_reg;
		end
	end
endmodule

//--- hdl/cmc_edge.sv
// edge detector and sticky interrupt flag
// assumes the level is already synchronous to clk
`timescale 1ns/1ps
module cmc_edge (
	input wire logic clk,
	input wire logic sys_rst,
	cmc_out_if.edge_unit p
);
	import cmc_pkg::*;
	logic prev_reg;
	logic hit;
	assign hit = (p.level & ~prev_reg & p.rise_en) | (~p.level & prev_reg & p.fall_en);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= p.level;
		end
	end
	// set beats a simultaneous clear so no edge is lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			p.flag <= 1'b0;
		end else if (hit) begin
			p.flag <= 1'b1;
		end else if (p.clr) begin
			p.flag <= 1'b0;
		end
	end
endmodule

//--- hdl/cmc_top.sv
// comparator control logic with ahb-lite register slave
// assumes raw comparison is asynchronous and t1_clk_fall is a one-cycle strobe in clk domain
`timescale 1ns/1ps
module cmc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic raw_compare,
	input wire logic [1:0] t1_clk_source,
	input wire logic t1_clk_fall,
	input wire logic sleep_mode,
	input wire logic [cmc_pkg::CMC_PORT_W-1:0] port_pins,
	input wire logic [cmc_pkg::CMC_PORT_W-1:0] analog_pin_select,
	output logic comparator_enable,
	output logic hysteresis_enable,
	output logic speed_power_select,
	output logic [2:0] neg_input_select,
	output logic [2:0] pos_input_select,
	output logic cmp_out,
	output logic waveform_shutdown,
	output logic comparator_irq_flag,
	output logic wake_request
);
	import cmc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic irq_en_reg;
	logic sd_en_reg;
	logic sync_out_reg;
	logic raw_sync;
	logic pol_level;
	logic cond_level;
	logic t1_stops;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic rd_ctrl0;
	cmc_state_t state_reg;
	cmc_out_if oif();

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	cmc_sync2 u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d_async(raw_compare),
		.q(raw_sync)
	);

	// disabled comparator output reads low before polarity, so toggling
	// enable or polarity can itself raise an edge
	assign pol_level = (raw_sync & ctrl0_reg[CMC_EN_BIT]) ^ ctrl0_reg[CMC_POL_BIT];
	assign t1_stops = sleep_mode &&
		(t1_clk_source == CMC_T1_FOSC || t1_clk_source == CMC_T1_FOSC4);

	// latch on the timer1 source falling edge, except in sleep with a FOSC or FOSC/4 source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_out_reg <= 1'b0;
		end else if (t1_clk_fall && !t1_stops) begin
			sync_out_reg <= pol_level;
		end
	end

	assign cond_level = ctrl0_reg[CMC_SYNC_BIT] ? sync_out_reg : pol_level;

	assign oif.level = cond_level;
	assign oif.rise_en = ctrl1_reg[CMC_RISE_BIT];
	assign oif.fall_en = ctrl1_reg[CMC_FALL_BIT];
	assign oif.clr = wr_pend_reg && hready && addr_hit(wr_addr_reg, CMC_OFS_IRQ)
		&& hwdata[CMC_IRQ_FLAG_BIT];

	cmc_edge u_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.p(oif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite: zero wait states, writes land in the data phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= CMC_ADDR;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready) begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr[7:0];
			state_reg <= (hsel && htrans[1]) ? CMC_DATA : CMC_ADDR;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl0_reg <= CMC_CTRL0_RST;
			ctrl1_reg <= CMC_CTRL1_RST;
			irq_en_reg <= 1'b0;
			sd_en_reg <= 1'b0;
		end else if (wr_pend_reg && hready && state_reg == CMC_DATA) begin
			if (addr_hit(wr_addr_reg, CMC_OFS_CTRL0)) begin
				ctrl0_reg <= hwdata[7:0] & CMC_CTRL0_WMASK;
			end else if (addr_hit(wr_addr_reg, CMC_OFS_CTRL1)) begin
				ctrl1_reg <= hwdata[7:0];
			end else if (addr_hit(wr_addr_reg, CMC_OFS_IRQ)) begin
				irq_en_reg <= hwdata[CMC_IRQ_IE_BIT];
				sd_en_reg <= hwdata[CMC_IRQ_SD_BIT];
			end
		end
	end

	assign rd_ctrl0 = hsel && htrans[1] && !hwrite && hready;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (hsel && htrans[1] && !hwrite && hready) begin
			if (addr_hit(haddr[7:0], CMC_OFS_CTRL0)) begin
				hrdata <= {24'h000000, ctrl0_reg[7], cond_level, ctrl0_reg[5:0]};
			end else if (addr_hit(haddr[7:0], CMC_OFS_CTRL1)) begin
				hrdata <= {24'h000000, ctrl1_reg};
			end else if (addr_hit(haddr[7:0], CMC_OFS_OUT)) begin
				hrdata <= {31'h00000000, cond_level};
			end else if (addr_hit(haddr[7:0], CMC_OFS_IRQ)) begin
				hrdata <= {29'h00000000, sd_en_reg, irq_en_reg, oif.flag};
			end else if (addr_hit(haddr[7:0], CMC_OFS_PORT)) begin
				hrdata <= {24'h000000, port_pins & ~analog_pin_select};
			end else begin
				hrdata <= 32'h00000000;
			end
		end else if (!rd_ctrl0 && hready) begin
			hrdata <= 32'h00000000;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			comparator_enable <= 1'b0;
			hysteresis_enable <= 1'b0;
			speed_power_select <= 1'b1;
			neg_input_select <= 3'h0;
			pos_input_select <= 3'h0;
			cmp_out <= 1'b0;
			waveform_shutdown <= 1'b0;
			comparator_irq_flag <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			comparator_enable <= ctrl0_reg[CMC_EN_BIT];
			hysteresis_enable <= ctrl0_reg[CMC_HYS_BIT];
			speed_power_select <= ctrl0_reg[CMC_SP_BIT];
			neg_input_select <= ctrl1_reg[2:0];
			pos_input_select <= ctrl1_reg[5:3];
			cmp_out <= cond_level;
			waveform_shutdown <= cond_level & sd_en_reg;
			comparator_irq_flag <= oif.flag;
			wake_request <= oif.flag & irq_en_reg;
		end
	end
endmodule

//--- bench/cmc_far.sv
// far side: analog core and timer1 falling-edge strobe
// assumes the bench drives lvl and tick after clk edges
`timescale 1ns/1ps
module cmc_far (
	input wire logic clk,
	input wire logic lvl,
	input wire logic tick,
	output logic raw_compare,
	output logic t1_clk_fall = 1'b0
);
	// skewed off the clock so the synchroniser sees a true async edge
	assign #3 raw_compare = lvl;
	always @(posedge clk) t1_clk_fall <= tick;
endmodule

//--- bench/cmc_chk.sv
// assertions on the comparator control top ports
// assumes synchronous active-high reset
`timescale 1ns/1ps
module cmc_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic comparator_enable,
	input wire logic hysteresis_enable,
	input wire logic speed_power_select,
	input wire logic [2:0] neg_input_select,
	input wire logic cmp_out,
	input wire logic waveform_shutdown,
	input wire logic comparator_irq_flag,
	input wire logic wake_request
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_SP: assert property ($past(sys_rst) |-> speed_power_select)
		else $error("speed bit not one after reset");
	AST_EN: assert property ($past(sys_rst) |-> !comparator_enable)
		else $error("enable set after reset");
	AST_HYS: assert property ($past(sys_rst) |-> !hysteresis_enable)
		else $error("hysteresis set after reset");
	AST_NEG: assert property ($past(sys_rst) |-> neg_input_select == 3'h0)
		else $error("neg select not zero after reset");
	AST_OUT: assert property ($past(sys_rst) |-> !cmp_out)
		else $error("output set after reset");
	AST_FLG: assert property ($past(sys_rst) |-> !comparator_irq_flag)
		else $error("flag set after reset");
	// output and shutdown leave the same register stage
	AST_WSD: assert property (waveform_shutdown |-> cmp_out)
		else $error("shutdown without active output");
	AST_WAKE: assert property (wake_request |-> comparator_irq_flag)
		else $error("wake without flag");
endmodule
bind cmc_top cmc_chk u_chk (.clk, .sys_rst, .comparator_enable, .hysteresis_enable,
	.speed_power_select, .neg_input_select, .cmp_out, .waveform_shutdown,
	.comparator_irq_flag, .wake_request);

//--- bench/testbench.sv
// self-checking bench for the comparator control top
// assumes a zero-wait ahb-lite slave
`timescale 1ns/1ps
module testbench;
	import cmc_pkg::*;
	logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, lvl = 0, tick = 0, sleep_mode = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0, t1_clk_source = 0;
	logic [7:0] port_pins = 0, analog_pin_select = 0;
	logic hreadyout, hresp, raw_compare, t1_clk_fall, comparator_enable, hysteresis_enable;
	logic speed_power_select, cmp_out, waveform_shutdown, comparator_irq_flag, wake_request;
	logic [2:0] neg_input_select, pos_input_select;
	int n_errors = 0, checks_done = 0;
	cmc_top DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .raw_compare, .t1_clk_source,
		.t1_clk_fall, .sleep_mode, .port_pins, .analog_pin_select, .comparator_enable,
		.hysteresis_enable, .speed_power_select, .neg_input_select, .pos_input_select,
		.cmp_out, .waveform_shutdown, .comparator_irq_flag, .wake_request);
	cmc_far FAR (.clk, .lvl, .tick, .raw_compare, .t1_clk_fall);
	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task ck(input logic [31:0] s, input logic [31:0] e, input string nm);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	// bounded: a hung slave ends the run instead of stalling it
	task wt;
		int i;
		i = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 20) begin
				n_errors++;
				test_done;
			end
			@(posedge clk);
		end
	endtask
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wt;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		q = hrdata;
	endtask
	task pl;
		tick <= 1;
		@(posedge clk);
		tick <= 0;
		cy(4);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reg;
		xf(0, CMC_OFS_CTRL0, 0);
		ck(q, 32'h04, "ctrl0 reset");
		xf(1, CMC_OFS_CTRL0, 32'hFE);
		cy(6);
		xf(0, CMC_OFS_CTRL0, 0);
		ck(q, 32'hD6, "ctrl0 inverted");
		ck(comparator_enable & hysteresis_enable, 1, "enable hyst");
		lvl <= 1;
		cy(6);
		xf(0, CMC_OFS_CTRL0, 0);
		ck(q, 32'h96, "ctrl0 result");
		$display("t_reg done");
	endtask
	task t_neg;
		for (int i = 0; i < 8; i++) begin
			xf(1, CMC_OFS_CTRL1, i * 9);
			cy(2);
			ck(neg_input_select, i, "neg select");
			ck(pos_input_select, i, "pos select");
		end
		$display("t_neg done");
	endtask
	task t_irq;
		lvl <= 0;
		xf(1, CMC_OFS_CTRL0, 32'h84);
		xf(1, CMC_OFS_CTRL1, 32'h80);
		xf(1, CMC_OFS_IRQ, 32'h07);
		cy(6);
		ck(comparator_irq_flag, 0, "flag idle");
		lvl <= 1;
		cy(6);
		ck(wake_request, 1, "wake");
		ck(waveform_shutdown, 1, "shutdown");
		lvl <= 0;
		cy(6);
		ck(comparator_irq_flag, 1, "flag sticky");
		ck(waveform_shutdown, 0, "shutdown off");
		xf(1, CMC_OFS_IRQ, 32'h07);
		cy(3);
		ck(comparator_irq_flag, 0, "flag clear");
		xf(1, CMC_OFS_CTRL1, 32'h40);
		xf(1, CMC_OFS_IRQ, 32'h01);
		lvl <= 1;
		cy(6);
		ck(comparator_irq_flag, 0, "rise masked");
		ck(waveform_shutdown, 0, "shutdown masked");
		// falling edge lands on the same edge as the clear write
		lvl <= 0;
		cy(1);
		xf(1, CMC_OFS_IRQ, 32'h01);
		cy(3);
		ck(comparator_irq_flag, 1, "set wins");
		ck(wake_request, 0, "wake masked");
		xf(1, CMC_OFS_IRQ, 32'h01);
		cy(3);
		ck(comparator_irq_flag, 0, "flag reclear");
		$display("t_irq done");
	endtask
	task t_sync;
		xf(1, CMC_OFS_CTRL0, 32'h85);
		pl;
		lvl <= 1;
		cy(6);
		ck(cmp_out, 0, "sync hold");
		pl;
		ck(cmp_out, 1, "sync update");
		sleep_mode <= 1;
		lvl <= 0;
		pl;
		ck(cmp_out, 1, "sleep freeze");
		t1_clk_source <= CMC_T1_FOSC;
		pl;
		ck(cmp_out, 1, "sleep freeze fosc");
		t1_clk_source <= CMC_T1_EXT;
		pl;
		ck(cmp_out, 0, "ext source");
		t1_clk_source <= CMC_T1_FOSC4;
		xf(1, CMC_OFS_CTRL0, 32'h84);
		lvl <= 1;
		cy(6);
		ck(cmp_out, 1, "sleep direct");
		lvl <= 0;
		sleep_mode <= 0;
		$display("t_sync done");
	endtask
	task t_misc;
		port_pins <= 8'hFF;
		analog_pin_select <= 8'h0F;
		xf(1, CMC_OFS_CTRL0, 32'h94);
		cy(6);
		xf(0, CMC_OFS_PORT, 0);
		ck(q, 32'hF0, "port");
		xf(0, CMC_OFS_OUT, 0);
		ck(q, 32'h01, "mirror");
		xf(1, 8'h40, 32'hFF);
		xf(0, 8'h40, 0);
		ck(q, 0, "unmapped");
		$display("t_misc done");
	endtask
	initial begin
		cy(5);
		sys_rst <= 0;
		cy(1);
		t_reg;
		t_neg;
		t_irq;
		t_sync;
		t_misc;
		test_done;
	end
endmodule
